/* ufc_uart.sv */
// Local design decision: strobed register access.
`timescale 1ns/1ps
module ufc_uart
  import ufc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire ufc_bus_s   bus,
  output logic [7:0]      rdata,
  input  wire logic       rxd,
  output logic            txd,
  input  wire logic       timer1_ovf,
  input  wire logic       count_input_pin,
  input  wire logic       external_trigger_pin,
  output logic            irq
);

  logic [2:0]      pin_meta;
  logic [2:0]      pin_sync;
  logic [2:0]      pin_prev;
  logic            rxd_s;
  logic            rx_fall;
  logic            t2_fall;
  logic            ex_fall;

  logic [7:0]      sctl;
  logic            framing_error_flag;
  logic [7:0]      power;
  logic [7:0]      slave_addr_value;
  logic [7:0]      slave_addr_mask;
  logic [7:0]      timer_two_control;
  logic [15:0]     reload;
  logic [7:0]      rx_buf;
  logic [ST_W-1:0] irq_stat;
  logic [ST_W-1:0] irq_en;
  logic [ST_W-1:0] irq_ev;
  logic [ST_W-1:0] irq_clr;

  logic            wr_sctl;
  logic            wr_sbuf;
  logic            wr_power;
  logic            wr_val;
  logic            wr_mask;
  logic            wr_t2;
  logic            wr_rlo;
  logic            wr_rhi;
  logic            wr_clr;
  logic            wr_en;

  logic            framing_select;
  logic [1:0]      mode;
  logic            nine;
  logic            async_mode;
  logic [1:0]      m2_cnt;
  logic            m2_tick;
  logic            rx_tick;
  logic            tx_tick;

  ufc_line_e       rx_state;
  logic [3:0]      rx_phase;
  logic [3:0]      rx_bitn;
  logic [8:0]      rx_shift;
  logic            rx_mid;
  logic [8:0]      rx_next;
  logic [8:0]      rx_src;
  logic [7:0]      rx_byte;
  logic            rx_last;
  logic            rx_end;
  logic            rx_deliver;
  logic            rx_bit9;
  logic            rx_accept;
  logic            fe_event;
  logic            addr_hit;

  ufc_line_e       tx_state;
  logic [3:0]      tx_phase;
  logic [3:0]      tx_bitn;
  logic [8:0]      tx_shift;
  logic            tx_start;
  logic            tx_bit_end;
  logic            tx_done;

  ufc_t2cfg_s      t2cfg;
  logic [15:0]     t2_count;
  logic            t2_ovf;
  logic            t2_ext;
  logic            t2_capture;
  logic            tf2_set;

  // ===========================================================================
  // pin synchronisers: {rxd, count pin, trigger pin}
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
      pin_prev <= PIN_IDLE;
    end else begin
      pin_meta <= {rxd, count_input_pin, external_trigger_pin};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // ===========================================================================
  // decode and baud selection
  always_comb begin
    rxd_s      = pin_sync[2];
    rx_fall    = pin_prev[2] && !pin_sync[2];
    t2_fall    = pin_prev[1] && !pin_sync[1];
    ex_fall    = pin_prev[0] && !pin_sync[0];
    wr_sctl    = bus.wr && (bus.addr == OFS_SCTL);
    wr_sbuf    = bus.wr && (bus.addr == OFS_SBUF);
    wr_power   = bus.wr && (bus.addr == OFS_POWER);
    wr_val     = bus.wr && (bus.addr == OFS_SA_VAL);
    wr_mask    = bus.wr && (bus.addr == OFS_SA_MASK);
    wr_t2      = bus.wr && (bus.addr == OFS_T2CTL);
    wr_rlo     = bus.wr && (bus.addr == OFS_RLD_LO);
    wr_rhi     = bus.wr && (bus.addr == OFS_RLD_HI);
    wr_clr     = bus.wr && (bus.addr == OFS_IRQ_CLR);
    wr_en      = bus.wr && (bus.addr == OFS_IRQ_EN);
    framing_select = power[PC_FRAME];
    mode       = {sctl[SC_TOP], sctl[SC_MODE1]};
    nine       = mode[1];
    async_mode = (mode != MODE_SYNC);
    m2_tick    = (m2_cnt == (power[PC_DBL] ? M2_DBL : M2_LAST));
    // separate selects keep rx and tx rates independent, except in mode 2 where both use m2_tick
    rx_tick    = (mode == MODE_9FIX) ? m2_tick :
                 (timer_two_control[T2_RCLK] ? t2_ovf : timer1_ovf); // R9 R16
    tx_tick    = (mode == MODE_9FIX) ? m2_tick :
                 (timer_two_control[T2_TX_BAUD_SOURCE_SEL] ? t2_ovf : timer1_ovf); // R10
    t2cfg.run      = timer_two_control[T2_RUN];
    t2cfg.ct_sel   = timer_two_control[T2_CT];
    t2cfg.cp_rl    = timer_two_control[T2_CPRL];
    t2cfg.exen     = timer_two_control[T2_EXEN];
    t2cfg.baud_use = timer_two_control[T2_RCLK] ||
                     timer_two_control[T2_TX_BAUD_SOURCE_SEL];
    tf2_set    = t2_ovf && !t2cfg.baud_use; // R12
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      m2_cnt <= 2'h0;
    end else begin
      m2_cnt <= m2_tick ? 2'h0 : m2_cnt + 2'h1;
    end
  end

  // ===========================================================================
  // receiver
  always_comb begin
    rx_mid     = rx_tick && (rx_phase == OVS_MID);
    rx_next    = {rxd_s, rx_shift[8:1]};
    rx_src     = (rx_state == LS_STOP) ? rx_shift : rx_next;
    rx_byte    = nine ? rx_src[7:0] : rx_src[8:1];
    rx_last    = (rx_state == LS_DATA) && rx_mid &&
                 (rx_bitn == (nine ? LAST9 : LAST8));
    rx_end     = (rx_state == LS_STOP) && rx_mid;
    rx_deliver = framing_select ? rx_end : rx_last; // R4
    // stop bit is not yet seen when mode 1 delivers early
    if (nine) begin
      rx_bit9 = (rx_state == LS_STOP) ? rx_shift[8] : rxd_s;
    end else begin
      rx_bit9 = (rx_state == LS_STOP) ? rxd_s : 1'b1;
    end
    rx_accept  = rx_deliver && !sctl[SC_RI] &&
                 (!(sctl[SC_MULTI] && nine) || (rx_bit9 && addr_hit)); // R18
    fe_event   = rx_end && framing_select && !rxd_s; // R1 R2
  end

  ufc_addr_match u_match (
    .value   (slave_addr_value),
    .mask    (slave_addr_mask),
    .rx_byte (rx_byte),
    .hit     (addr_hit)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_state <= LS_IDLE;
      rx_phase <= 4'h0;
      rx_bitn  <= 4'h0;
      rx_shift <= 9'h000;
    end else begin
      if (rx_tick) begin
        rx_phase <= rx_phase + 4'h1;
      end
      case (rx_state)
        LS_IDLE: begin
          if (sctl[SC_REN] && async_mode && rx_fall) begin
            rx_state <= LS_START;
            rx_phase <= 4'h0;
          end
        end
        LS_START: begin
          if (rx_mid) begin
            // a short glitch is dropped as a false start
            rx_state <= rxd_s ? LS_IDLE : LS_DATA;
            rx_bitn  <= 4'h0;
          end
        end
        LS_DATA: begin
          if (rx_mid) begin
            rx_shift <= rx_next;
            rx_bitn  <= rx_bitn + 4'h1;
            if (rx_last) begin
              rx_state <= LS_STOP;
            end
          end
        end
        LS_STOP: begin
          if (rx_mid) begin
            rx_state <= LS_IDLE;
          end
        end
        default: begin
          rx_state <= LS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_buf <= RST_BYTE;
    end else if (rx_accept) begin
      rx_buf <= rx_byte;
    end
  end

  // ===========================================================================
  // transmitter
  always_comb begin
    tx_start   = wr_sbuf && async_mode && (tx_state == LS_IDLE);
    tx_bit_end = tx_tick && (tx_phase == OVS_LAST);
    tx_done    = (tx_state == LS_STOP) && tx_bit_end;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_state <= LS_IDLE;
      tx_phase <= 4'h0;
      tx_bitn  <= 4'h0;
      tx_shift <= 9'h000;
    end else begin
      if (tx_tick) begin
        tx_phase <= tx_phase + 4'h1;
      end
      case (tx_state)
        LS_IDLE: begin
          if (tx_start) begin
            tx_state <= LS_START;
            tx_phase <= 4'h0;
            tx_bitn  <= 4'h0;
            tx_shift <= {sctl[SC_TB8], bus.wdata};
          end
        end
        LS_START: begin
          if (tx_bit_end) begin
            tx_state <= LS_DATA;
          end
        end
        LS_DATA: begin
          if (tx_bit_end) begin
            tx_shift <= {1'b1, tx_shift[8:1]};
            tx_bitn  <= tx_bitn + 4'h1;
            if (tx_bitn == (nine ? LAST9 : LAST8)) begin
              tx_state <= LS_STOP;
            end
          end
        end
        LS_STOP: begin
          if (tx_bit_end) begin
            tx_state <= LS_IDLE;
          end
        end
        default: begin
          tx_state <= LS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      txd <= 1'b1;
    end else begin
      case (tx_state)
        LS_START: txd <= 1'b0;
        LS_DATA:  txd <= tx_shift[0];
        default:  txd <= 1'b1;
      endcase
    end
  end

  // ===========================================================================
  // serial control, power control, address registers
  always_ff @(posedge clk) begin
    if (reset) begin
      sctl               <= RST_BYTE;
      framing_error_flag <= 1'b0;
    end else begin
      if (wr_sctl) begin
        sctl[6:0] <= bus.wdata[6:0];
        if (framing_select) begin
          framing_error_flag <= bus.wdata[SC_TOP]; // R17 R3
        end else begin
          sctl[SC_TOP] <= bus.wdata[SC_TOP]; // R17
        end
      end
      // hardware events placed last so a set beats a clear
      if (rx_accept) begin
        sctl[SC_RI]  <= 1'b1;
        sctl[SC_RB8] <= rx_bit9;
      end
      if (tx_done) begin
        sctl[SC_TI] <= 1'b1;
      end
      if (fe_event) begin
        framing_error_flag <= 1'b1; // R2 R3
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      power            <= RST_BYTE;
      slave_addr_value <= RST_BYTE; // R7
      slave_addr_mask  <= RST_BYTE; // R7
    end else begin
      if (wr_power) begin
        power <= bus.wdata & PC_WMASK;
      end
      if (wr_val) begin
        slave_addr_value <= bus.wdata; // R8
      end
      if (wr_mask) begin
        slave_addr_mask <= bus.wdata; // R8
      end
    end
  end

  // ===========================================================================
  // timer 2 and its control
  ufc_timer2 u_timer2 (
    .clk       (clk),
    .reset     (reset),
    .cfg       (t2cfg),
    .pin_fall  (t2_fall),
    .trig_fall (ex_fall),
    .reload    (reload),
    .count     (t2_count),
    .ovf       (t2_ovf),
    .ext_hit   (t2_ext),
    .capture   (t2_capture)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      timer_two_control <= RST_BYTE;
      reload            <= RST_WORD;
    end else begin
      if (wr_t2) begin
        timer_two_control <= bus.wdata;
      end
      if (tf2_set) begin
        timer_two_control[T2_OVF] <= 1'b1; // R12
      end
      if (t2_ext) begin
        timer_two_control[T2_EXT] <= 1'b1;
      end
      if (wr_rlo) begin
        reload[7:0] <= bus.wdata;
      end
      if (wr_rhi) begin
        reload[15:8] <= bus.wdata;
      end
      if (t2_capture) begin
        reload <= t2_count;
      end
    end
  end

  // ===========================================================================
  // interrupt status, enable, output
  always_comb begin
    irq_ev  = {t2_ext, tf2_set, fe_event, tx_done, rx_accept};
    irq_clr = wr_clr ? bus.wdata[ST_W-1:0] : '0;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_stat <= '0;
      irq_en   <= '0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
      if (wr_en) begin
        irq_en <= bus.wdata[ST_W-1:0];
      end
      irq <= |(irq_stat & irq_en);
    end
  end

  // ===========================================================================
  // read port
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= RST_BYTE;
    end else if (bus.rd) begin
      case (bus.addr)
        OFS_SCTL:    rdata <= {framing_select ? framing_error_flag
                                              : sctl[SC_TOP],
                               sctl[6:0]}; // R17
        OFS_SBUF:    rdata <= rx_buf;
        OFS_POWER:   rdata <= power;
        OFS_SA_VAL:  rdata <= slave_addr_value;
        OFS_SA_MASK: rdata <= slave_addr_mask;
        OFS_T2CTL:   rdata <= timer_two_control;
        OFS_RLD_LO:  rdata <= reload[7:0];
        OFS_RLD_HI:  rdata <= reload[15:8];
        OFS_IRQ_ST:  rdata <= {3'h0, irq_stat};
        OFS_IRQ_EN:  rdata <= {3'h0, irq_en};
        default:     rdata <= RST_BYTE;
      endcase
    end else begin
      rdata <= RST_BYTE;
    end
  end

  // ===========================================================================
  // checks
  chk_fe_raise : assert property ( // R2
    @(posedge clk) disable iff (reset)
    rx_end && framing_select && !rxd_s |=> framing_error_flag)
    else $error("bad stop bit not flagged");

  chk_fe_disabled : assert property ( // R1
    @(posedge clk) disable iff (reset)
    !framing_select && !framing_error_flag && !wr_sctl
    |=> !framing_error_flag)
    else $error("framing error set while check off");

  chk_fe_sticky : assert property ( // R3
    @(posedge clk) disable iff (reset)
    framing_error_flag && !wr_sctl |=> framing_error_flag)
    else $error("framing error cleared by hardware");

  chk_ri_at_stop : assert property ( // R4
    @(posedge clk) disable iff (reset)
    $rose(sctl[SC_RI]) && !$past(wr_sctl) && $past(framing_select)
    |-> $past(rx_state) == LS_STOP)
    else $error("receive done not at stop bit");

  chk_ri_at_data : assert property ( // R4
    @(posedge clk) disable iff (reset)
    $rose(sctl[SC_RI]) && !$past(wr_sctl) && !$past(framing_select)
    |-> $past(rx_state) == LS_DATA)
    else $error("receive done not at last data bit");

  chk_addr_reset : assert property ( // R7
    @(posedge clk) disable iff (reset)
    $fell(reset) |-> slave_addr_value == RST_BYTE &&
                     slave_addr_mask == RST_BYTE)
    else $error("address registers not cleared");

  chk_rx_source : assert property ( // R9
    @(posedge clk) disable iff (reset)
    rx_state != LS_IDLE && mode == MODE_8VAR &&
    !timer_two_control[T2_RCLK] && !timer1_ovf |=> $stable(rx_phase))
    else $error("receive ticked without timer 1");

  chk_tx_source : assert property ( // R10
    @(posedge clk) disable iff (reset)
    tx_state != LS_IDLE && mode == MODE_9VAR &&
    timer_two_control[T2_TX_BAUD_SOURCE_SEL] && !t2_ovf |=> $stable(tx_phase))
    else $error("transmit ticked without timer 2");

  chk_tf2_set : assert property ( // R12
    @(posedge clk) disable iff (reset)
    t2_ovf && !t2cfg.baud_use |=> timer_two_control[T2_OVF])
    else $error("timer 2 overflow flag missed");

  chk_tf2_block : assert property ( // R12
    @(posedge clk) disable iff (reset)
    t2_ovf && t2cfg.baud_use && !timer_two_control[T2_OVF] && !wr_t2
    |=> !timer_two_control[T2_OVF])
    else $error("overflow flag set in baud use");

  chk_addr_filter : assert property ( // R18
    @(posedge clk) disable iff (reset)
    $rose(sctl[SC_RI]) && !$past(wr_sctl) && $past(sctl[SC_MULTI]) &&
    $past(nine) |-> $past(addr_hit) && sctl[SC_RB8])
    else $error("unmatched address byte accepted");

  chk_fe_view : assert property ( // R17
    @(posedge clk) disable iff (reset)
    bus.rd && bus.addr == OFS_SCTL && framing_select
    |=> rdata[SC_TOP] == $past(framing_error_flag))
    else $error("bit 7 not showing framing error");

  cov_fe : cover property (
    @(posedge clk) disable iff (reset) fe_event);

  cov_addr_accept : cover property (
    @(posedge clk) disable iff (reset)
    rx_accept && sctl[SC_MULTI] && nine);

  cov_duplex : cover property ( // R16
    @(posedge clk) disable iff (reset)
    rx_state == LS_DATA && tx_state == LS_DATA);

endmodule

/* ufc_pkg.sv */
// Functional notes
// R1 - Stop-bit framing check exists in async modes 1-3, only when framing select set.
// R2 - Enabled check flags a framing error when a frame's stop bit is low.
// R3 - Framing error stays until software clears it or reset; good frames leave it.
// R4 - With framing check on, receive done rises at stop bit, else last data bit.
// R5 - Given address: stored address bits compared only where mask bit is one.
// R6 - Broadcast address is address OR mask; zero bits are don't-care.
// R7 - Reset clears address and mask, so every address matches.
// R8 - Address and mask are plain whole-byte registers.
// R9 - Modes 1 and 3: receive tick from timer 1, or timer 2 when selected.
// R10 - Modes 1 and 3: transmit tick from timer 1, or timer 2 when selected.
// R11 - Timer 2 used for baud forces auto-reload, capture select ignored.
// R12 - Timer 2 overflow flag set only when no baud source uses it; software clears.
// R13 - Trigger falling edge captures or reloads only if enabled and not baud.
// R14 - Timer 2 counts only while its run bit is set.
// R15 - Timer 2 counts clock cycles, or count pin falling edges when selected.
// R16 - Transmitter and receiver run at once, each on its own tick.
// R17 - Serial control bit 7 shows mode bit zero or framing error per framing select.
// R18 - Nine-bit multiprocessor receive accepts an address byte only on a match.
package ufc_pkg;

  // ===========================================================================
  // register offsets
  localparam logic [7:0] OFS_POWER   = 8'h87;
  localparam logic [7:0] OFS_SCTL    = 8'h98;
  localparam logic [7:0] OFS_SBUF    = 8'h99;
  localparam logic [7:0] OFS_SA_VAL  = 8'hA9;
  localparam logic [7:0] OFS_SA_MASK = 8'hB9;
  localparam logic [7:0] OFS_T2CTL   = 8'hC8;
  localparam logic [7:0] OFS_RLD_LO  = 8'hCA;
  localparam logic [7:0] OFS_RLD_HI  = 8'hCB;
  localparam logic [7:0] OFS_IRQ_ST  = 8'hE0;
  localparam logic [7:0] OFS_IRQ_CLR = 8'hE1;
  localparam logic [7:0] OFS_IRQ_EN  = 8'hE2;

  // ===========================================================================
  // field positions
  localparam int SC_TOP   = 7;
  localparam int SC_MODE1 = 6;
  localparam int SC_MULTI = 5;
  localparam int SC_REN   = 4;
  localparam int SC_TB8   = 3;
  localparam int SC_RB8   = 2;
  localparam int SC_TI    = 1;
  localparam int SC_RI    = 0;
  localparam int PC_DBL   = 7;
  localparam int PC_FRAME = 6;
  localparam int T2_OVF   = 7;
  localparam int T2_EXT   = 6;
  localparam int T2_RCLK  = 5;
  localparam int T2_TX_BAUD_SOURCE_SEL  = 4;
  localparam int T2_EXEN  = 3;
  localparam int T2_RUN   = 2;
  localparam int T2_CT    = 1;
  localparam int T2_CPRL  = 0;
  localparam int ST_W     = 5;

  // ===========================================================================
  // reset values and timing
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [2:0]  PIN_IDLE  = 3'h7;
  localparam logic [7:0]  PC_WMASK  = 8'hDF;
  localparam logic [3:0]  OVS_MID   = 4'h7;
  localparam logic [3:0]  OVS_LAST  = 4'hF;
  localparam logic [3:0]  LAST8     = 4'h7;
  localparam logic [3:0]  LAST9     = 4'h8;
  localparam logic [1:0]  M2_LAST   = 2'h3;
  localparam logic [1:0]  M2_DBL    = 2'h1;
  localparam logic [15:0] T2_MAX    = 16'hFFFF;
  localparam logic [1:0]  MODE_SYNC = 2'h0;
  localparam logic [1:0]  MODE_8VAR = 2'h1;
  localparam logic [1:0]  MODE_9FIX = 2'h2;
  localparam logic [1:0]  MODE_9VAR = 2'h3;

  typedef enum logic [1:0] {
    LS_IDLE  = 2'b00,
    LS_START = 2'b01,
    LS_DATA  = 2'b10,
    LS_STOP  = 2'b11
  } ufc_line_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ufc_bus_s;

  typedef struct packed {
    logic run;
    logic ct_sel;
    logic cp_rl;
    logic exen;
    logic baud_use;
  } ufc_t2cfg_s;

endpackage

/* ufc_addr_match.sv */
`timescale 1ns/1ps
module ufc_addr_match
  import ufc_pkg::*;
(
  input  wire logic [7:0] value,
  input  wire logic [7:0] mask,
  input  wire logic [7:0] rx_byte,
  output logic            hit
);

  logic [7:0] given_ok;
  logic [7:0] bcast_ok;

  // ===========================================================================
  // per-bit compare
  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign given_ok[i] = !mask[i] || (rx_byte[i] == value[i]); // R5
    assign bcast_ok[i] = !(value[i] || mask[i]) || rx_byte[i]; // R6
  end

  assign hit = (&given_ok) || (&bcast_ok);

endmodule

/* ufc_timer2.sv */
`timescale 1ns/1ps
module ufc_timer2
  import ufc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire ufc_t2cfg_s  cfg,
  input  wire logic        pin_fall,
  input  wire logic        trig_fall,
  input  wire logic [15:0] reload,
  output logic [15:0]      count,
  output logic             ovf,
  output logic             ext_hit,
  output logic             capture
);

  logic tick;

  // ===========================================================================
  // count enable and events
  always_comb begin
    tick    = cfg.run && (cfg.ct_sel ? pin_fall : 1'b1); // R14 R15
    ovf     = tick && (count == T2_MAX);
    ext_hit = cfg.exen && trig_fall && !cfg.baud_use; // R13
    capture = ext_hit && cfg.cp_rl;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count <= RST_WORD;
    end else if (ovf) begin
      // baud use overrides capture mode
      count <= (cfg.baud_use || !cfg.cp_rl) ? reload : RST_WORD; // R11
    end else if (ext_hit && !cfg.cp_rl) begin
      count <= reload; // R13
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end

  // ===========================================================================
  // checks
  chk_t2_halted : assert property ( // R14
    @(posedge clk) disable iff (reset)
    !cfg.run && !trig_fall |=> $stable(count))
    else $error("timer 2 moved while stopped");

  chk_t2_pin : assert property ( // R15
    @(posedge clk) disable iff (reset)
    cfg.run && cfg.ct_sel && !pin_fall && !trig_fall |=> $stable(count))
    else $error("timer 2 counted without pin edge");

  chk_t2_baud_reload : assert property ( // R11
    @(posedge clk) disable iff (reset)
    ovf && cfg.baud_use |=> count == $past(reload))
    else $error("timer 2 not reloaded in baud use");

  chk_t2_trig_ignore : assert property ( // R13
    @(posedge clk) disable iff (reset)
    trig_fall && cfg.baud_use && !tick |=> $stable(count))
    else $error("trigger acted during baud use");

endmodule

/* ufc_node.sv */
`timescale 1ns/1ps
// =========================
// remote node on the line
module ufc_node (
  input  wire logic clk,
  input  wire logic tx,
  output logic      line
);
  initial line = 1'h1;
  // 16 ticks of 4 clk per bit in mode 2, lsb first
  task automatic send(input logic [8:0] d, input logic stop);
    logic [10:0] f;
    f = {stop, d, 1'h0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk) line <= f[i];
      repeat (63) @(posedge clk);
    end
    // back to idle high, so after a bad stop bit the next start bit still gives a falling edge
    @(posedge clk) line <= 1'h1;
  endtask
  // device transmit line, 16 clk per bit, sampled mid bit
  task automatic recv(output logic [9:0] r);
    @(negedge tx);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      repeat (16) @(posedge clk);
      r[i] = tx;
    end
  endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ps
// =========================
// bench
module testbench
  import ufc_pkg::*;
;
  logic       clk, reset, rxd, txd, irq, nb, e, tp;
  logic [1:0] t1c;
  logic [9:0] r;
  ufc_bus_s   bus;
  logic [7:0] rdata, a, b, s, m;
  logic [7:0] tbl [5] = '{8'h00, 8'hF0, 8'hFB, 8'hF3, 8'hF7};
  int         mismatches = 0, check_count = 0, seed, cyc = 0;
  ufc_uart dut (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
    .rxd(rxd), .txd(txd), .timer1_ovf(&t1c), .count_input_pin(1'h1),
    .external_trigger_pin(tp), .irq(irq));
  ufc_node node (.clk(clk), .tx(txd), .line(rxd));
  // timer 1 stand-in: one overflow pulse every 4 clk
  always @(posedge clk) t1c <= reset ? 2'h0 : t1c + 2'h1;
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, ex);
    check_count++;
    if (g !== ex) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, g, ex);
    end
  endtask
  task automatic wr(input logic [7:0] ad, d);
    @(posedge clk) bus <= {2'h2, ad, d};
    @(posedge clk) bus <= '0;
  endtask
  task automatic chk(input logic [7:0] ad, ex);
    logic [7:0] g;
    @(posedge clk) bus <= {2'h1, ad, 8'h00};
    @(posedge clk) bus <= '0;
    #1 g = rdata;
    cmp(g, ex);
  endtask
  // given match ignores zero mask bits, broadcast ignores zero bits of address OR mask
  function automatic logic hit(input logic [7:0] x, sv, mv);
    logic [7:0] b;
    b = sv | mv;
    return (((x ^ sv) & mv) == 8'h00) || (((x ^ b) & b) == 8'h00);
  endfunction
  initial begin
    bus = '0;
    tp = 1'h1;
    reset = 1'h1;
    seed = 99;
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    chk(OFS_SA_VAL, 8'h00);
    chk(OFS_SA_MASK, 8'h00);
    chk(OFS_T2CTL, 8'h00);
    chk(8'h10, 8'h00);
    s = 8'($random(seed));
    m = 8'h00;
    wr(OFS_SA_VAL, s);
    chk(OFS_SA_VAL, s);
    $display("registers done");
    wr(OFS_SCTL, 8'hB0);
    wr(OFS_IRQ_EN, 8'h05);
    for (int i = 0; i < 7; i++) begin
      if (i == 1) begin
        s = 8'hF1;
        m = 8'hFA;
        wr(OFS_SA_VAL, s);
        wr(OFS_SA_MASK, m);
      end
      a = (i < 5) ? tbl[i] : 8'($random(seed));
      // last frame is a data byte, dropped in multiprocessor mode
      nb = (i != 6);
      node.send({nb, a}, 1'h1);
      e = hit(a, s, m) && nb;
      chk(OFS_IRQ_ST, {7'h00, e});
      cmp({7'h00, irq}, {7'h00, e});
      wr(OFS_IRQ_CLR, 8'h1F);
      wr(OFS_SCTL, 8'hB0);
    end
    $display("address match done");
    wr(OFS_SCTL, 8'h90);
    wr(OFS_POWER, 8'h40);
    wr(OFS_IRQ_EN, 8'h04);
    node.send(9'h1A5, 1'h0);
    chk(OFS_SCTL, 8'h95);
    chk(OFS_IRQ_ST, 8'h05);
    cmp({7'h00, irq}, 8'h01);
    wr(OFS_IRQ_EN, 8'h01);
    wr(OFS_IRQ_CLR, 8'h01);
    wr(OFS_SCTL, 8'h90);
    // framing error still pending but masked
    cmp({7'h00, irq}, 8'h00);
    node.send(9'h05A, 1'h1);
    chk(OFS_SCTL, 8'h91);
    chk(OFS_IRQ_ST, 8'h05);
    wr(OFS_SCTL, 8'h10);
    chk(OFS_SCTL, 8'h10);
    wr(OFS_POWER, 8'h00);
    chk(OFS_SCTL, 8'h90);
    $display("framing done");
    wr(OFS_RLD_LO, 8'hFF);
    wr(OFS_RLD_HI, 8'hFF);
    wr(OFS_T2CTL, 8'h0C);
    tp <= 1'h0;
    repeat (6) @(posedge clk);
    chk(OFS_T2CTL, 8'hCC);
    // first write races a same-cycle overflow; hardware set wins
    wr(OFS_T2CTL, 8'h14);
    wr(OFS_T2CTL, 8'h14);
    wr(OFS_SCTL, 8'h50);
    wr(OFS_IRQ_CLR, 8'h1F);
    a = 8'($random(seed));
    b = 8'($random(seed));
    fork
      node.send({1'h1, a}, 1'h1);
      begin
        wr(OFS_SBUF, b);
        node.recv(r);
      end
    join
    cmp(r[7:0], b);
    cmp({6'h00, r[9:8]}, 8'h03);
    chk(OFS_SBUF, a);
    chk(OFS_SCTL, 8'h57);
    chk(OFS_IRQ_ST, 8'h03);
    chk(OFS_T2CTL, 8'h14);
    $display("baud sources done");
    stop_test();
  end
endmodule
